// file: include/cwf_pkg.sv
// Package for the CAN wake-frame filter configuration store
`default_nettype none
package cwf_pkg;
    // Register byte offsets on the register port
    localparam logic [6:0] OFS_CONFIG_VALID         = 7'h20;
    localparam logic [6:0] OFS_WAKE_ID_BITS_20_13   = 7'h24;
    localparam logic [6:0] OFS_WAKE_ID_BITS_12_5    = 7'h25;
    localparam logic [6:0] OFS_WAKE_ID_LOW_TYPE     = 7'h26;
    localparam logic [6:0] OFS_ID_COMPARE_28_21     = 7'h27;
    localparam logic [6:0] OFS_ID_COMPARE_20_13     = 7'h28;
    localparam logic [6:0] OFS_ID_COMPARE_12_5      = 7'h29;
    localparam logic [6:0] OFS_ID_COMPARE_4_0       = 7'h2A;
    localparam logic [6:0] OFS_PAYLOAD_LENGTH       = 7'h2B;
    localparam logic [6:0] OFS_PAYLOAD_BYTE_SEVEN   = 7'h2C;
    localparam logic [6:0] OFS_PAYLOAD_BYTE_SIX     = 7'h2D;

    // Filter bytes sit in a flop array, index = offset - first filter offset
    localparam int unsigned NUM_FILT = 10;
    localparam logic [3:0] IDX_ID_20_13  = 4'h0;
    localparam logic [3:0] IDX_ID_12_5   = 4'h1;
    localparam logic [3:0] IDX_ID_LOW    = 4'h2;
    localparam logic [3:0] IDX_CMP_28_21 = 4'h3;
    localparam logic [3:0] IDX_CMP_20_13 = 4'h4;
    localparam logic [3:0] IDX_CMP_12_5  = 4'h5;
    localparam logic [3:0] IDX_CMP_4_0   = 4'h6;
    localparam logic [3:0] IDX_LENGTH    = 4'h7;
    localparam logic [3:0] IDX_BYTE7     = 4'h8;
    localparam logic [3:0] IDX_BYTE6     = 4'h9;

    // Writable bits per filter byte; reserved bits are never stored
    localparam logic [NUM_FILT-1:0][7:0] WRITE_MASK = {
        8'hFF, 8'hFF, 8'h0F, 8'h7C, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF};
    localparam logic [7:0] FILT_RESET = 8'h00;

    // Field positions inside the lowest identifier byte and the config valid register
    localparam int unsigned LOW_ID_HI  = 6;
    localparam int unsigned LOW_ID_LO  = 2;
    localparam int unsigned LOW_RTR    = 1;
    localparam int unsigned LOW_IDE    = 0;
    localparam int unsigned CFG_VALID_BIT = 0;

    // Standard identifiers occupy identifier bits 28 down to 18
    localparam logic [28:0] STD_ID_SPAN = 29'h1FFC0000;
    localparam logic [3:0]  MAX_PAYLOAD = 4'h8;

    typedef struct packed {
        logic            valid;
        logic [28:0]     ident;
        logic            rtr;
        logic            ide;
        logic [3:0]      dlc;
        logic [7:0][7:0] data;
    } cwf_frame_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cwf_reg_req_t;

    typedef struct packed {
        logic [NUM_FILT-1:0][7:0] filt_q;
        logic                     cfg_valid_q;
        logic [7:0]               rd_data_q;
        logic                     match_q;
    } cwf_state_t;
endpackage
`default_nettype wire

// file: src/cwf_filter_config.sv
// Wake-frame filter configuration store with frame comparator
//
// Functional notes
// [R01] Identifier bits 20..13 in one RW byte
// [R02] Identifier bits 12..5 in own RW byte
// [R03] Identifier bits 4..0 at positions 6..2
// [R04] Bit 1 selects data or remote frame
// [R05] Bit 0 selects standard or extended identifier
// [R06] Software keeps remote-request selection at zero
// [R07] Compare bit one compares, zero ignores
// [R08] Compare bytes mirror the identifier layout
// [R09] Reserved bits ignore writes, read zero
// [R10] Length code four bits in 3..0
// [R11] Length codes above seven mean eight
// [R12] Payload bytes seven and six own bytes
// [R13] Reset and soft reset clear registers; soft reset keeps the identifier bits 12..5 byte
// [R14] Restart keeps contents, length top zero
// [R15] Valid flag set by software, cleared by device
// [R16] Standard identifier taken from bits 28..18
// [R17] Match needs every configured field equal
`default_nettype none
module cwf_filter_config (
    input  wire logic                 core_clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 soft_reset_i,
    input  wire logic                 restart_i,
    input  wire cwf_pkg::cwf_reg_req_t reg_req_i,
    input  wire logic [7:0]           ident_top_i,
    input  wire logic [5:0][7:0]      payload_low_i,
    input  wire cwf_pkg::cwf_frame_t  frame_i,
    output logic [7:0]                rd_data_o,
    output logic                      config_valid_flag_o,
    output logic                      wake_frame_match_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic filt_hit(input logic [6:0] addr);
        filt_hit = (addr >= cwf_pkg::OFS_WAKE_ID_BITS_20_13)
                && (addr <= cwf_pkg::OFS_PAYLOAD_BYTE_SIX);
    endfunction

    function automatic logic [3:0] filt_index(input logic [6:0] addr);
        logic [6:0] diff;
        diff = addr - cwf_pkg::OFS_WAKE_ID_BITS_20_13;
        filt_index = diff[3:0];
    endfunction

    // Codes above seven carry eight bytes
    function automatic logic [3:0] payload_len(input logic [3:0] dlc);
        payload_len = (dlc > 4'h7) ? cwf_pkg::MAX_PAYLOAD : dlc; // see [R11]
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configured frame fields

    cwf_pkg::cwf_state_t s_q;
    cwf_pkg::cwf_state_t s_d;

    logic [28:0]     cfg_ident;
    logic [28:0]     cfg_compare;
    logic [28:0]     cmp_enable;
    logic            cfg_rtr;
    logic            cfg_ide;
    logic [3:0]      cfg_len;
    logic [7:0][7:0] cfg_data;
    logic [7:0]      byte_ok;
    logic            ident_ok;
    logic            frame_ok;

    assign cfg_ident = {ident_top_i,
                        s_q.filt_q[cwf_pkg::IDX_ID_20_13],      // see [R01]
                        s_q.filt_q[cwf_pkg::IDX_ID_12_5],       // see [R02]
                        s_q.filt_q[cwf_pkg::IDX_ID_LOW][cwf_pkg::LOW_ID_HI:cwf_pkg::LOW_ID_LO]};
    assign cfg_compare = {s_q.filt_q[cwf_pkg::IDX_CMP_28_21],   // see [R08]
                          s_q.filt_q[cwf_pkg::IDX_CMP_20_13],
                          s_q.filt_q[cwf_pkg::IDX_CMP_12_5],
                          s_q.filt_q[cwf_pkg::IDX_CMP_4_0][cwf_pkg::LOW_ID_HI:cwf_pkg::LOW_ID_LO]};
    assign cfg_rtr = s_q.filt_q[cwf_pkg::IDX_ID_LOW][cwf_pkg::LOW_RTR];  // see [R04]
    assign cfg_ide = s_q.filt_q[cwf_pkg::IDX_ID_LOW][cwf_pkg::LOW_IDE];  // see [R05]
    assign cfg_len = payload_len(s_q.filt_q[cwf_pkg::IDX_LENGTH][3:0]);  // see [R10]
    assign cfg_data = {s_q.filt_q[cwf_pkg::IDX_BYTE7],                   // see [R12]
                       s_q.filt_q[cwf_pkg::IDX_BYTE6],
                       payload_low_i};

    // Standard frames only carry the top eleven identifier bits
    assign cmp_enable = cfg_ide ? cfg_compare
                                : (cfg_compare & cwf_pkg::STD_ID_SPAN);   // see [R16]
    assign ident_ok = ((frame_i.ident ^ cfg_ident) & cmp_enable) == 29'h00000000; // see [R07]

    // Bytes beyond the indicated length are don't care
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_byte
            assign byte_ok[gi] = (4'(gi) >= cfg_len)
                              || (frame_i.data[gi] == cfg_data[gi]);
        end
    endgenerate

    // A remote frame is compared as configured; software must not pick one
    assign frame_ok = ident_ok                                // see [R17]
                   && (frame_i.rtr == cfg_rtr)                // see [R06]
                   && (frame_i.ide == cfg_ide)
                   && (payload_len(frame_i.dlc) == cfg_len)
                   && (&byte_ok);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic [3:0] idx;
        logic       wr_filt;
        idx = filt_index(reg_req_i.addr);
        wr_filt = reg_req_i.wr && filt_hit(reg_req_i.addr);
        s_d = s_q;
        s_d.match_q = frame_i.valid && s_q.cfg_valid_q && frame_ok;
        s_d.rd_data_q = 8'h00;

        // Masked store keeps reserved bits at zero
        if (wr_filt)
        begin
            s_d.filt_q[idx] = reg_req_i.wdata & cwf_pkg::WRITE_MASK[idx]; // see [R09]
        end

        // Device drops the flag on wake or any filter change
        if (s_d.match_q || wr_filt)
        begin
            s_d.cfg_valid_q = 1'b0;                                // see [R15]
        end
        if (reg_req_i.wr && (reg_req_i.addr == cwf_pkg::OFS_CONFIG_VALID))
        begin
            s_d.cfg_valid_q = reg_req_i.wdata[cwf_pkg::CFG_VALID_BIT]; // see [R15]
        end

        // Restart keeps configuration; length top nibble is never stored
        if (restart_i)
        begin
            s_d.filt_q[cwf_pkg::IDX_LENGTH][7:4] = 4'h0;           // see [R14]
        end

        if (reg_req_i.rd)
        begin
            if (reg_req_i.addr == cwf_pkg::OFS_CONFIG_VALID)
            begin
                s_d.rd_data_q = {7'h00, s_q.cfg_valid_q};
            end
            else if (filt_hit(reg_req_i.addr))
            begin
                s_d.rd_data_q = s_q.filt_q[idx] & cwf_pkg::WRITE_MASK[idx]; // see [R09]
            end
            else
            begin
                s_d.rd_data_q = 8'h00;
            end
        end

        // Soft reset spares the identifier bits 12..5 byte
        if (soft_reset_i)
        begin
            for (int i = 0; i < int'(cwf_pkg::NUM_FILT); i++)
            begin
                if (4'(i) != cwf_pkg::IDX_ID_12_5)
                begin
                    s_d.filt_q[i] = cwf_pkg::FILT_RESET;           // see [R13]
                end
            end
            s_d.cfg_valid_q = 1'b0;
            s_d.match_q = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            s_q <= '0;                                             // see [R13]
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rd_data_o = s_q.rd_data_q;
    assign config_valid_flag_o = s_q.cfg_valid_q;
    assign wake_frame_match_o = s_q.match_q;

endmodule
`default_nettype wire

// file: tb/cwf_can_node.sv
// Other CAN node: puts one frame on the filter input per send request
`default_nettype none
module cwf_can_node (
    input  wire logic                 core_clk_i,
    input  wire logic                 send_i,
    input  wire cwf_pkg::cwf_frame_t  frm_i,
    output var cwf_pkg::cwf_frame_t   frame_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Fields invert outside the valid cycle so a stale frame never looks good
    always_ff @(posedge core_clk_i)
    begin
        frame_o       <= send_i ? frm_i : ~frm_i;
        frame_o.valid <= send_i;
    end
endmodule
`default_nettype wire

// file: tb/cwf_filter_config_monitor.sv
// Port checker for the filter configuration store
`default_nettype none
module cwf_filter_config_monitor (
    input wire logic                  core_clk_i,
    input wire logic                  reset_i,
    input wire logic                  soft_reset_i,
    input wire cwf_pkg::cwf_reg_req_t reg_req_i,
    input wire cwf_pkg::cwf_frame_t   frame_i,
    input wire logic [7:0]            rd_data_o,
    input wire logic                  config_valid_flag_o,
    input wire logic                  wake_frame_match_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////
    sequence wr_then_rd(a);
        reg_req_i.wr && reg_req_i.addr == a && !soft_reset_i
        ##1 reg_req_i.rd && reg_req_i.addr == a && !soft_reset_i;
    endsequence
    // Readback keeps only the writable bits
    property wr_rd(a, m);
        wr_then_rd(a) |=> rd_data_o == ($past(reg_req_i.wdata, 2) & m);
    endproperty
    id_upper_a: assert property (wr_rd(7'h24, 8'hFF)) else $error("id byte");
    id_low_a: assert property (wr_rd(7'h26, 8'h7F)) else $error("id low byte");
    cmp_low_a: assert property (wr_rd(7'h2A, 8'h7C)) else $error("compare low");
    len_code_a: assert property (wr_rd(7'h2B, 8'h0F)) else $error("length");
    byte_six_a: assert property (wr_rd(7'h2D, 8'hFF)) else $error("byte six");
    rd_idle_a: assert property (!reg_req_i.rd |=> rd_data_o == 8'h00)
        else $error("read data not idle");
    match_cause_a: assert property (wake_frame_match_o |->
        $past(frame_i.valid) && $past(config_valid_flag_o)) else $error("stray match");
    match_clear_a: assert property (wake_frame_match_o && !$past(reg_req_i.wr)
        |-> !config_valid_flag_o) else $error("valid kept after match");
    edit_clear_a: assert property (reg_req_i.wr && reg_req_i.addr inside {[7'h24:7'h2D]}
        |=> !config_valid_flag_o) else $error("valid kept after edit");
    soft_clear_a: assert property (soft_reset_i |=> !config_valid_flag_o)
        else $error("valid kept after soft reset");
endmodule
bind cwf_filter_config cwf_filter_config_monitor cwf_filter_config_monitor_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .soft_reset_i(soft_reset_i),
    .reg_req_i(reg_req_i), .frame_i(frame_i), .rd_data_o(rd_data_o),
    .config_valid_flag_o(config_valid_flag_o), .wake_frame_match_o(wake_frame_match_o));
`default_nettype wire

// file: tb/cwf_filter_config_tb_top.sv
// Self-checking bench for the wake-frame filter configuration store
`default_nettype none
module cwf_filter_config_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [47:0]     PLOW = 48'h0123456789AB;
    localparam logic [28:0]     SID  = 29'h14BFFFFF;
    localparam logic [9:0][7:0] MSK  = {8'hFF, 8'hFF, 8'h0F, 8'h7C, 8'hFF,
                                        8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF};
    logic                  core_clk_i = 1'b0;
    logic                  reset_i = 1'b1;
    logic                  soft_reset_i = 1'b0;
    logic                  restart_i = 1'b0;
    logic                  send = 1'b0;
    cwf_pkg::cwf_reg_req_t reg_req_i = '0;
    cwf_pkg::cwf_frame_t   frm = '0;
    cwf_pkg::cwf_frame_t   frame_i;
    logic [7:0]            rd_data_o;
    logic                  config_valid_flag_o;
    logic                  wake_frame_match_o;
    int                    fails = 0;
    int                    checks = 0;
    always #4 core_clk_i = ~core_clk_i;
    cwf_can_node cwf_can_node_i (.core_clk_i(core_clk_i), .send_i(send), .frm_i(frm),
        .frame_o(frame_i));
    cwf_filter_config cwf_filter_config_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .soft_reset_i(soft_reset_i), .restart_i(restart_i), .reg_req_i(reg_req_i),
        .ident_top_i(8'hA5), .payload_low_i(PLOW), .frame_i(frame_i), .rd_data_o(rd_data_o),
        .config_valid_flag_o(config_valid_flag_o), .wake_frame_match_o(wake_frame_match_o));
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        reg_req_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk_i);
        reg_req_i <= '0;
        @(posedge core_clk_i);
        chk(rd_data_o, e);
    endtask
    // Every write is read back at once, so no write strobe is ever left standing
    task automatic wrc(input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
        reg_req_i <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk_i);
        rdc(a, e);
    endtask
    task automatic fr(input logic [28:0] id, input logic ide, input logic [7:0] b7,
                      input logic e);
        frm <= '{1'b1, id, 1'b0, ide, 4'hF, {b7, 8'h00, PLOW}};
        send <= 1'b1;
        @(posedge core_clk_i);
        send <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        chk({7'h00, wake_frame_match_o}, {7'h00, e});
    endtask
    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        for (int i = 0; i < 10; i++)
            rdc(7'h24 + 7'(i), 8'h00);
        for (int i = 0; i < 10; i++)
            wrc(7'h24 + 7'(i), 8'hFF, MSK[i]);
        wrc(7'h7F, 8'hFF, 8'h00);
        restart_i <= 1'b1;
        @(posedge core_clk_i);
        restart_i <= 1'b0;
        rdc(7'h2B, 8'h0F);
        soft_reset_i <= 1'b1;
        @(posedge core_clk_i);
        soft_reset_i <= 1'b0;
        rdc(7'h25, 8'hFF);
        rdc(7'h2D, 8'h00);
        wrc(7'h26, 8'h01, 8'h01);
        wrc(7'h2B, 8'h0F, 8'h0F);
        wrc(7'h20, 8'h01, 8'h01);
        fr(29'h0ABCDE, 1'b1, 8'h00, 1'b1);
        chk({7'h00, config_valid_flag_o}, 8'h00);
        fr(29'h0ABCDE, 1'b1, 8'h00, 1'b0);
        wrc(7'h2A, 8'h7C, 8'h7C);
        wrc(7'h20, 8'h01, 8'h01);
        fr(29'h00000001, 1'b1, 8'h00, 1'b0);
        fr(29'h1FFFFFE0, 1'b1, 8'h00, 1'b1);
        wrc(7'h27, 8'hFF, 8'hFF);
        wrc(7'h29, 8'hFF, 8'hFF);
        wrc(7'h26, 8'h00, 8'h00);
        wrc(7'h2B, 8'h09, 8'h09);
        wrc(7'h2C, 8'h77, 8'h77);
        wrc(7'h20, 8'h01, 8'h01);
        fr(SID, 1'b1, 8'h77, 1'b0);
        fr(SID, 1'b0, 8'h76, 1'b0);
        fr(SID, 1'b0, 8'h77, 1'b1);
        close_out;
    end
    initial
    begin
        repeat (3000) @(posedge core_clk_i);
        fails++;
        close_out;
    end
endmodule
`default_nettype wire
